// >>> design/dtmf_pkg.sv
package dtmf_pkg;
    // ----------------------------------------------------------------
    // time base and timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int TB_HZ = 3_579_545;
    localparam logic [31:0] TB_STEP = 32'((64'(TB_HZ) << 32) / 64'(CLK_HZ));
    localparam int MS_W = 12;
    localparam int TB_PER_MS = (TB_HZ + 999) / 1000;
    localparam logic [MS_W-1:0] MS_LAST = MS_W'(TB_PER_MS - 1);
    localparam int CNT_W = 6;
    localparam int RX_ACCEPT_MS = 30;
    localparam int RX_PAUSE_MS = 30;
    localparam int CP_ON_MS = 25;
    localparam int CP_OFF_MS = 30;
    localparam logic [CNT_W-1:0] RX_ACCEPT_LAST = CNT_W'(RX_ACCEPT_MS - 1);
    localparam logic [CNT_W-1:0] RX_PAUSE_LAST = CNT_W'(RX_PAUSE_MS - 1);
    localparam logic [CNT_W-1:0] CP_ON_LAST = CNT_W'(CP_ON_MS - 1);
    localparam logic [CNT_W-1:0] CP_OFF_LAST = CNT_W'(CP_OFF_MS - 1);
    // ----------------------------------------------------------------
    // tones and digit codes
    // ----------------------------------------------------------------
    localparam int TONE_ACC_W = 24;
    function automatic logic [TONE_ACC_W-1:0] tone_step(input int hz);
        logic [63:0] num;
        num = (64'(hz) << TONE_ACC_W) + 64'(TB_HZ / 2);
        return TONE_ACC_W'(num / 64'(TB_HZ));
    endfunction
    localparam logic [TONE_ACC_W-1:0] ROW_STEP [4] = '{tone_step(697), tone_step(770),
                                                       tone_step(852), tone_step(941)};
    localparam logic [TONE_ACC_W-1:0] COL_STEP [4] = '{tone_step(1209), tone_step(1336),
                                                       tone_step(1477), tone_step(1633)};
    // code for row * 4 + column
    localparam logic [3:0] DIGIT_CODE [16] = '{4'h1, 4'h2, 4'h3, 4'hD, 4'h4, 4'h5, 4'h6, 4'hE,
                                               4'h7, 4'h8, 4'h9, 4'hF, 4'hB, 4'hA, 4'hC, 4'h0};
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_MASK = 8'h08;
    localparam logic [7:0] A_STATE = 8'h0C;
    localparam logic [7:0] A_WORD = 8'hFC;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam int CTRL_RX_EN = 0;
    localparam int CTRL_CP_EN = 1;
    localparam int EV_DETECT = 0;
    localparam int EV_RELEASE = 1;
    localparam int EV_CP_ON = 2;
    localparam int EV_CP_OFF = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------------------------------
    // state types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {RX_IDLE, RX_QUAL, RX_HOLD} rx_state_e;
    typedef struct packed {
        logic [TONE_ACC_W-1:0] phase;
        logic                  wave;
    } osc_s;
    typedef struct packed {
        logic            aw_got;
        logic            w_got;
        logic [7:0]      awaddr;
        logic [31:0]     wdata;
        logic            wlane0;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
        logic [1:0]      ctrl;
        logic [3:0]      status;
        logic [3:0]      mask;
        logic            irq;
        logic            strap_ext;
        logic            osc_out;
        logic [31:0]     tb_acc;
        logic            ext_s1;
        logic            ext_s2;
        logic            ext_s3;
        logic [MS_W-1:0] ms_cnt;
        logic            ms_tick;
        rx_state_e       rx_state;
        logic [CNT_W-1:0] rx_cnt;
        logic [3:0]      rx_cand;
        logic [3:0]      rx_code;
        logic            code_valid;
        logic            cp_on;
        logic [CNT_W-1:0] cp_cnt;
        logic            ld_s1;
        logic            ld_s2;
        logic            ld_s3;
        logic            rs_s1;
        logic            rs_s2;
        logic [3:0]      cd_s1;
        logic [3:0]      cd_s2;
        logic [3:0]      gen_code;
        logic            gen_active;
    } st_s;
endpackage

// >>> design/tone_osc.sv
`timescale 1ns/1ps
`default_nettype none
module tone_osc #(
    parameter int ACC_W = dtmf_pkg::TONE_ACC_W
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // control
    input  wire logic             tick,
    input  wire logic             enable,
    input  wire logic [ACC_W-1:0] step,
    // tone
    output logic                  wave
);
    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (ACC_W != dtmf_pkg::TONE_ACC_W) begin : g_bad_width
        $error("tone_osc accumulator width must match the package");
    end

    dtmf_pkg::osc_s st;
    dtmf_pkg::osc_s next_st;

    // ----------------------------------------------------------------
    // phase accumulator, square wave from its top bit
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (!enable) begin
            next_st = '0;
        end else if (tick) begin
            next_st.phase = st.phase + step;
            next_st.wave = next_st.phase[ACC_W-1];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wave = st.wave;
endmodule
`default_nettype wire

// >>> design/dtmf_transceiver_digital_core.sv
`timescale 1ns/1ps
`default_nettype none
module dtmf_transceiver_digital_core #(
    parameter int TB_PER_MS = dtmf_pkg::TB_PER_MS
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // interrupt
    output logic             irq,
    // receiver tone detectors and outputs
    input  wire logic [3:0]  rx_row_hit,
    input  wire logic [3:0]  rx_col_hit,
    input  wire logic        rx_bus_drive_n,
    output logic [3:0]       rx_code_bits_out,
    output logic             rx_code_bits_oe,
    output logic             code_valid_flag,
    // call progress
    input  wire logic        cp_band_energy,
    output logic             call_progress_present,
    // generator
    input  wire logic [3:0]  gen_code_bits,
    input  wire logic        gen_load_n,
    input  wire logic        gen_reset,
    output logic [1:0]       gen_tone_wave,
    output logic             gen_active,
    // time base
    input  wire logic        osc_pad_in,
    output logic             osc_pad_out,
    input  wire logic        oscillator_select,
    input  wire logic        shared_timebase_clock_in,
    output logic             shared_timebase_clock_out,
    output logic             shared_timebase_clock_oe
);
    dtmf_pkg::st_s st;
    dtmf_pkg::st_s next_st;

    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (TB_PER_MS < 2 || TB_PER_MS > (1 << dtmf_pkg::MS_W)) begin : g_bad_prescale
        $error("millisecond prescale out of range");
    end

    localparam int              MS_W   = dtmf_pkg::MS_W;
    localparam logic [MS_W-1:0] MS_END = MS_W'(TB_PER_MS - 1);

    logic       pair_ok;
    logic [3:0] pair_code;
    logic [3:0] gen_rc;

    // ----------------------------------------------------------------
    // tone pair decode
    // ----------------------------------------------------------------
    always_comb begin
        logic [1:0] r;
        logic [1:0] c;
        r = '0;
        c = '0;
        for (int i = 0; i < 4; i++) begin
            if (rx_row_hit[i]) r = 2'(i);
            if (rx_col_hit[i]) c = 2'(i);
        end
        pair_ok = $onehot(rx_row_hit) && $onehot(rx_col_hit) && st.ctrl[dtmf_pkg::CTRL_RX_EN];
        pair_code = dtmf_pkg::DIGIT_CODE[{r, c}];
    end

    // generator code back to row and column
    always_comb begin
        gen_rc = '0;
        for (int i = 0; i < 16; i++) begin
            if (dtmf_pkg::DIGIT_CODE[i] == st.gen_code) gen_rc = 4'(i);
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [3:0]  ev;
        logic [3:0]  clr;
        logic [32:0] acc_sum;
        logic        tb_tick;
        logic        load_fall;
        ev = '0;
        clr = '0;
        acc_sum = {1'b0, st.tb_acc} + {1'b0, dtmf_pkg::TB_STEP};
        tb_tick = 1'b0;
        load_fall = st.ld_s3 && !st.ld_s2;
        next_st = st;
        next_st.ms_tick = 1'b0;

        // time base: own oscillator or shared pin
        next_st.strap_ext = osc_pad_in && !oscillator_select;
        next_st.osc_out = !osc_pad_in;
        next_st.ext_s1 = shared_timebase_clock_in;
        next_st.ext_s2 = st.ext_s1;
        next_st.ext_s3 = st.ext_s2;
        next_st.tb_acc = acc_sum[31:0];
        if (st.strap_ext) begin
            tb_tick = st.ext_s2 && !st.ext_s3;
        end else begin
            tb_tick = acc_sum[32];
        end
        if (tb_tick) begin
            if (st.ms_cnt == MS_END) begin
                next_st.ms_cnt = '0;
                next_st.ms_tick = 1'b1;
            end else begin
                next_st.ms_cnt = st.ms_cnt + 1'b1;
            end
        end

        // receiver post-processor
        case (st.rx_state)
            dtmf_pkg::RX_IDLE: begin
                if (pair_ok) begin
                    next_st.rx_state = dtmf_pkg::RX_QUAL;
                    next_st.rx_cand = pair_code;
                    next_st.rx_cnt = '0;
                end
            end
            dtmf_pkg::RX_QUAL: begin
                if (!pair_ok) begin
                    next_st.rx_state = dtmf_pkg::RX_IDLE;
                end else if (pair_code != st.rx_cand) begin
                    next_st.rx_cand = pair_code;
                    next_st.rx_cnt = '0;
                end else if (st.ms_tick) begin
                    if (st.rx_cnt == dtmf_pkg::RX_ACCEPT_LAST) begin
                        next_st.rx_state = dtmf_pkg::RX_HOLD;
                        next_st.rx_code = st.rx_cand;
                        next_st.code_valid = 1'b1;
                        next_st.rx_cnt = '0;
                        ev[dtmf_pkg::EV_DETECT] = 1'b1;
                    end else begin
                        next_st.rx_cnt = st.rx_cnt + 1'b1;
                    end
                end
            end
            dtmf_pkg::RX_HOLD: begin
                if (pair_ok) begin
                    next_st.rx_cnt = '0;
                end else if (st.ms_tick) begin
                    if (st.rx_cnt == dtmf_pkg::RX_PAUSE_LAST) begin
                        next_st.rx_state = dtmf_pkg::RX_IDLE;
                        next_st.rx_code = '0;
                        next_st.code_valid = 1'b0;
                        next_st.rx_cnt = '0;
                        ev[dtmf_pkg::EV_RELEASE] = 1'b1;
                    end else begin
                        next_st.rx_cnt = st.rx_cnt + 1'b1;
                    end
                end
            end
            default: begin
                next_st.rx_state = dtmf_pkg::RX_IDLE;
            end
        endcase

        // call-progress cadence follower
        if (cp_band_energy && st.ctrl[dtmf_pkg::CTRL_CP_EN]) begin
            if (st.cp_on) begin
                next_st.cp_cnt = '0;
            end else if (st.ms_tick) begin
                if (st.cp_cnt == dtmf_pkg::CP_ON_LAST) begin
                    next_st.cp_on = 1'b1;
                    next_st.cp_cnt = '0;
                    ev[dtmf_pkg::EV_CP_ON] = 1'b1;
                end else begin
                    next_st.cp_cnt = st.cp_cnt + 1'b1;
                end
            end
        end else begin
            if (!st.cp_on) begin
                next_st.cp_cnt = '0;
            end else if (st.ms_tick) begin
                if (st.cp_cnt == dtmf_pkg::CP_OFF_LAST) begin
                    next_st.cp_on = 1'b0;
                    next_st.cp_cnt = '0;
                    ev[dtmf_pkg::EV_CP_OFF] = 1'b1;
                end else begin
                    next_st.cp_cnt = st.cp_cnt + 1'b1;
                end
            end
        end

        // generator input synchronisers and latch
        next_st.ld_s1 = gen_load_n;
        next_st.ld_s2 = st.ld_s1;
        next_st.ld_s3 = st.ld_s2;
        next_st.rs_s1 = gen_reset;
        next_st.rs_s2 = st.rs_s1;
        next_st.cd_s1 = gen_code_bits;
        next_st.cd_s2 = st.cd_s1;
        if (st.rs_s2) begin
            next_st.gen_active = 1'b0;
        end else if (load_fall) begin
            next_st.gen_code = st.cd_s2;
            next_st.gen_active = 1'b1;
        end

        // register writes
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wlane0 = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = dtmf_pkg::RESP_OKAY;
            if ((st.awaddr & dtmf_pkg::A_WORD) == dtmf_pkg::A_CTRL) begin
                if (st.wlane0) next_st.ctrl = st.wdata[1:0];
            end else if ((st.awaddr & dtmf_pkg::A_WORD) == dtmf_pkg::A_STATUS) begin
                if (st.wlane0) clr = st.wdata[3:0];
            end else if ((st.awaddr & dtmf_pkg::A_WORD) == dtmf_pkg::A_MASK) begin
                if (st.wlane0) next_st.mask = st.wdata[3:0];
            end else if ((st.awaddr & dtmf_pkg::A_WORD) == dtmf_pkg::A_STATE) begin
                next_st.bresp = dtmf_pkg::RESP_OKAY;
            end else begin
                next_st.bresp = dtmf_pkg::RESP_SLVERR;
            end
        end

        // sticky status, a new event beats a clear
        next_st.status = (st.status & ~clr) | ev;
        next_st.irq = |(next_st.status & next_st.mask);

        // register reads
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = dtmf_pkg::RESP_OKAY;
            next_st.rdata = '0;
            if ((s_axi_araddr & dtmf_pkg::A_WORD) == dtmf_pkg::A_CTRL) begin
                next_st.rdata[1:0] = st.ctrl;
            end else if ((s_axi_araddr & dtmf_pkg::A_WORD) == dtmf_pkg::A_STATUS) begin
                next_st.rdata[3:0] = st.status;
            end else if ((s_axi_araddr & dtmf_pkg::A_WORD) == dtmf_pkg::A_MASK) begin
                next_st.rdata[3:0] = st.mask;
            end else if ((s_axi_araddr & dtmf_pkg::A_WORD) == dtmf_pkg::A_STATE) begin
                next_st.rdata[11:0] = {st.strap_ext, st.gen_active, st.gen_code,
                                       st.cp_on, st.code_valid, st.rx_code};
            end else begin
                next_st.rresp = dtmf_pkg::RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.ctrl <= dtmf_pkg::CTRL_RESET;
            st.ld_s1 <= 1'b1;
            st.ld_s2 <= 1'b1;
            st.ld_s3 <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // tone generators, row then column
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_tone
        logic [dtmf_pkg::TONE_ACC_W-1:0] step;
        assign step = (g == 0) ? dtmf_pkg::ROW_STEP[gen_rc[3:2]] : dtmf_pkg::COL_STEP[gen_rc[1:0]];
        tone_osc #(
            .ACC_W (dtmf_pkg::TONE_ACC_W)
        ) u_osc (
            .aclk    (aclk),
            .aresetn (aresetn),
            .tick    (st.ms_cnt != next_st.ms_cnt),
            .enable  (st.gen_active),
            .step    (step),
            .wave    (gen_tone_wave[g])
        );
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = !st.aw_got && !st.bvalid;
    assign s_axi_wready = !st.w_got && !st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rvalid = st.rvalid;
    assign irq = st.irq;
    assign rx_code_bits_out = st.rx_code;
    assign rx_code_bits_oe = !rx_bus_drive_n;
    assign code_valid_flag = st.code_valid;
    assign call_progress_present = st.cp_on;
    assign gen_active = st.gen_active;
    assign osc_pad_out = st.osc_out;
    assign shared_timebase_clock_out = st.tb_acc[31];
    assign shared_timebase_clock_oe = !st.strap_ext;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_float;
        rx_bus_drive_n |-> !rx_code_bits_oe;
    endproperty
    a_float: assert property (p_float) else $error("code bits driven while disabled");

    property p_code_map;
        $rose(code_valid_flag) |-> rx_code_bits_out == $past(st.rx_cand) && $past(pair_ok, 2);
    endproperty
    a_code_map: assert property (p_code_map) else $error("wrong code on detection");

    property p_release;
        $fell(code_valid_flag) |-> rx_code_bits_out == 4'h0 && $past(st.rx_cnt) == dtmf_pkg::RX_PAUSE_LAST;
    endproperty
    a_release: assert property (p_release) else $error("release without pause");

    property p_accept;
        $rose(code_valid_flag) |-> $past(st.rx_cnt) == dtmf_pkg::RX_ACCEPT_LAST;
    endproperty
    a_accept: assert property (p_accept) else $error("detection before tone time");

    property p_load;
        (st.ld_s3 && !st.ld_s2 && !st.rs_s2) |=> gen_active && st.gen_code == $past(st.cd_s2);
    endproperty
    a_load: assert property (p_load) else $error("load strobe not taken");

    property p_gen_reset;
        st.rs_s2 |=> !gen_active ##1 (!gen_active || $past(st.ld_s3 && !st.ld_s2));
    endproperty
    a_gen_reset: assert property (p_gen_reset) else $error("tones not stopped");

    property p_sync;
        $fell(st.ld_s2) |-> $past(gen_load_n, 3) && !$past(gen_load_n, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("load path not two stages");

    property p_cp_on;
        $rose(call_progress_present) |-> $past(st.cp_cnt) == dtmf_pkg::CP_ON_LAST && $past(cp_band_energy);
    endproperty
    a_cp_on: assert property (p_cp_on) else $error("presence before energy time");

    property p_cp_off;
        $fell(call_progress_present) |-> $past(st.cp_cnt) == dtmf_pkg::CP_OFF_LAST;
    endproperty
    a_cp_off: assert property (p_cp_off) else $error("presence dropped early");

    property p_ext_tb;
        st.strap_ext |-> !shared_timebase_clock_oe;
    endproperty
    a_ext_tb: assert property (p_ext_tb) else $error("time base pin driven in follower mode");
endmodule
`default_nettype wire

// >>> dv/dial_host.sv
`timescale 1ns/1ps
`default_nettype none
module dial_host (
    // clock
    input  wire logic aclk,
    // generator pins and time base
    output logic [3:0] code,
    output logic       load_n,
    output logic       rst,
    output logic       tb_clk
);
    initial {code, load_n, rst, tb_clk} = 7'h04;
    // free-running base of a crystal-strapped master
    always @(posedge aclk) tb_clk <= ~tb_clk;
    task dial(input logic [3:0] c);
        code <= c;
        repeat (3) @(posedge aclk);
        load_n <= 1'b0;
        repeat (3) @(posedge aclk);
        load_n <= 1'b1;
        code <= ~c;
    endtask
    task stop;
        rst <= 1'b1;
        repeat (3) @(posedge aclk);
        rst <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, rx_bus_drive_n, rx_code_bits_oe;
    logic code_valid_flag, cp_band_energy, call_progress_present, gen_load_n, gen_reset, gen_active, ext_tb;
    logic osc_pad_in, osc_pad_out, oscillator_select, shared_timebase_clock_out, shared_timebase_clock_oe;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb, rx_row_hit, rx_col_hit, rx_code_bits_out, gen_code_bits;
    logic [1:0]  s_axi_bresp, s_axi_rresp, gen_tone_wave;
    int          error_cnt, num_checks, n;
    // short millisecond; the host base ticks every other clock
    localparam int TB_MS    = 4;
    localparam int MS_CLK   = 2 * TB_MS;
    localparam int COL_HALF = 2 * dtmf_pkg::TB_HZ / (2 * 1209);
    wire shared_timebase_clock_in = shared_timebase_clock_oe ? shared_timebase_clock_out : ext_tb;
    wire [3:0] rx_bus = rx_code_bits_oe ? rx_code_bits_out : 4'hZ;
    dtmf_transceiver_digital_core #(.TB_PER_MS(TB_MS)) uut (.*);
    dial_host host (.aclk(aclk), .code(gen_code_bits), .load_n(gen_load_n), .rst(gen_reset), .tb_clk(ext_tb));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task give_verdict;
        if (error_cnt == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task guard(input int k, input int lim);
        if (k >= lim) begin
            error_cnt++;
            give_verdict;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 99 && !s_axi_bvalid; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        guard(n, 99);
        chk("bresp", s_axi_bresp, er);
        @(posedge aclk);
    endtask
    task rd(input logic [7:0] a, input logic [1:0] er);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 99 && !s_axi_rvalid; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        guard(n, 99);
        chk("rresp", s_axi_rresp, er);
        @(posedge aclk);
    endtask
    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task t_gen;
        for (int i = 0; i < 16; i++) begin
            host.dial(4'(i));
            repeat (3) @(posedge aclk);
            chk("gen_active", gen_active, 1);
            rd(dtmf_pkg::A_STATE, dtmf_pkg::RESP_OKAY);
            chk("gen_code", d[9:6], i);
            host.stop;
            repeat (4) @(posedge aclk);
            chk("gen_off", {gen_active, gen_tone_wave}, 0);
        end
    endtask
    task t_rx_cp;
        chk("tb_pin", {shared_timebase_clock_oe, osc_pad_out}, 0);
        wr(dtmf_pkg::A_MASK, 32'h4, dtmf_pkg::RESP_OKAY);
        {cp_band_energy, rx_row_hit, rx_col_hit} <= 9'h122;
        for (n = 0; n < 40 * MS_CLK && !irq; n++) @(posedge aclk);
        guard(n, 40 * MS_CLK);
        chk("cp_present", call_progress_present, 1);
        chk("early_valid", code_valid_flag, 0);
        for (n = 0; n < 40 * MS_CLK && !code_valid_flag; n++) @(posedge aclk);
        guard(n, 40 * MS_CLK);
        chk("rx_code", rx_bus, 4'h5);
        rd(dtmf_pkg::A_STATUS, dtmf_pkg::RESP_OKAY);
        chk("status", d, 32'h5);
        wr(dtmf_pkg::A_STATUS, 32'h4, dtmf_pkg::RESP_OKAY);
        rx_bus_drive_n <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("irq", irq, 0);
        chk("rx_float", rx_bus, 4'hZ);
    endtask
    task t_tone;
        host.dial(4'h1);
        for (n = 0; n < 4000 && !gen_tone_wave[1]; n++) @(posedge aclk);
        chk("col_half", n > COL_HALF - 30 && n < COL_HALF + 30, 1);
        chk("row_low", gen_tone_wave[0], 0);
        host.stop;
        repeat (4) @(posedge aclk);
    endtask
    task t_pause;
        rx_bus_drive_n <= 1'b0;
        {cp_band_energy, rx_row_hit} <= 5'h00;
        repeat (15 * MS_CLK) @(posedge aclk);
        {cp_band_energy, rx_row_hit} <= 5'h12;
        repeat (2) @(posedge aclk);
        chk("gap_bridged", {code_valid_flag, call_progress_present}, 2'h3);
        {cp_band_energy, rx_row_hit} <= 5'h00;
        repeat (45 * MS_CLK) @(posedge aclk);
        chk("released", {code_valid_flag, call_progress_present, rx_bus}, 6'h00);
        rd(dtmf_pkg::A_STATUS, dtmf_pkg::RESP_OKAY);
        chk("status_off", d, 32'hB);
        {cp_band_energy, rx_row_hit} <= 5'h12;
        repeat (10 * MS_CLK) @(posedge aclk);
        {cp_band_energy, rx_row_hit} <= 5'h00;
        repeat (MS_CLK) @(posedge aclk);
        chk("short_burst", {code_valid_flag, call_progress_present}, 2'h0);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {cp_band_energy, oscillator_select, rx_bus_drive_n, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, rx_row_hit, rx_col_hit} = '0;
        s_axi_wstrb = 4'hF;
        osc_pad_in = 1'b1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(dtmf_pkg::A_CTRL, dtmf_pkg::RESP_OKAY);
        chk("ctrl", d, 32'h3);
        rd(8'h20, dtmf_pkg::RESP_SLVERR);
        chk("unmapped", d, 0);
        wr(8'h20, 32'h1, dtmf_pkg::RESP_SLVERR);
        t_gen;
        t_tone;
        t_rx_cp;
        t_pause;
        give_verdict;
    end
endmodule
`default_nettype wire
